// ==== src/rpd_downstream_path.sv ====
// downstream data path of the remote phy node
`timescale 1ns/1ps
`default_nettype none
module rpd_downstream_path import rpd_pkg::*; #(
  parameter int FLOWS = 4,
  parameter int QDEPTH = 256,
  parameter logic [47:0] HEADEND_MAC = 48'h0200_0000_0001,
  parameter logic [47:0] SYNC_DEST_MAC = 48'h0300_0000_0001
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inValid,
  output logic inReady,
  input wire logic [7:0] inData,
  input wire logic inFirst,
  input wire logic inLast,
  input wire logic [1:0] inFlow,
  input wire logic [3:0] inStreamTag,
  output logic outValid,
  input wire logic outReady,
  output logic [7:0] outData,
  output logic outFirst,
  input wire logic ptpTick
);
  localparam int AW = $clog2(QDEPTH);
  localparam int FW = $clog2(FLOWS);

  logic [31:0] ctrl_ff;
  logic [31:0] syncIvl_ff;
  logic [31:0] flowPhb_ff;
  logic [7:0] timeLag_ff;
  logic [31:0] nullCnt_ff;
  logic [31:0] syncCnt_ff;
  logic [31:0] timeNow_ff;
  logic [31:0] ivlCnt_ff;
  logic [31:0] tsAcc_ff;
  logic tick1_ff;
  logic tick2_ff;
  logic tick3_ff;
  logic modeDirect;
  logic enable;
  logic directMap;
  assign modeDirect = ctrl_ff[CTRL_MODE_BIT];
  assign enable = ctrl_ff[CTRL_ENABLE_BIT];
  assign directMap = ctrl_ff[CTRL_DIRECT_MAP_BIT];

  // apb slave, zero wait state
  logic apbWr;
  logic apbHit;
  assign apbWr = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    apbHit = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: prdata = ctrl_ff;
      ADDR_STATUS: prdata = {28'h000_0000, outValid, inReady, 1'b0, modeDirect};
      ADDR_SYNC_IVL: prdata = syncIvl_ff;
      ADDR_TIME_NOW: prdata = timeNow_ff;
      ADDR_FLOW_PHB: prdata = flowPhb_ff;
      ADDR_NULL_CNT: prdata = nullCnt_ff;
      ADDR_SYNC_CNT: prdata = syncCnt_ff;
      ADDR_TIME_LAG: prdata = {24'h00_0000, timeLag_ff};
      default: apbHit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !apbHit;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RESET;
      syncIvl_ff <= SYNC_IVL_RESET;
      flowPhb_ff <= FLOW_PHB_RESET;
      timeLag_ff <= TIME_LAG_RESET;
    end else if (apbWr) begin
      if (paddr == ADDR_CTRL) ctrl_ff <= pwdata;
      if (paddr == ADDR_SYNC_IVL) syncIvl_ff <= pwdata;
      if (paddr == ADDR_FLOW_PHB) flowPhb_ff <= pwdata;
      if (paddr == ADDR_TIME_LAG) begin
        timeLag_ff <= (pwdata[7:0] > TIME_LAG_MAX) ? TIME_LAG_MAX : pwdata[7:0];
      end
    end
  end

  // timestamp: 10.24 MHz count from a fractional accumulator; the ptp tick only requests a sync
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick1_ff <= 1'b0;
      tick2_ff <= 1'b0;
      tick3_ff <= 1'b0;
    end else begin
      tick1_ff <= ptpTick;
      tick2_ff <= tick1_ff;
      tick3_ff <= tick2_ff;
    end
  end
  logic [31:0] tsAccSum;
  assign tsAccSum = tsAcc_ff + 32'(TSCLK_HZ / 1000 - MCLK_KHZ);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tsAcc_ff <= 32'h0000_0000;
      timeNow_ff <= 32'h0000_0000;
    end else begin
      // one or two counts per mclk, average 1.024
      if (tsAccSum >= 32'(MCLK_KHZ)) begin
        tsAcc_ff <= tsAccSum - 32'(MCLK_KHZ);
        timeNow_ff <= timeNow_ff + 32'h0000_0002;
      end else begin
        tsAcc_ff <= tsAccSum;
        timeNow_ff <= timeNow_ff + 32'h0000_0001;
      end
    end
  end
  logic [31:0] stampTime;
  assign stampTime = timeNow_ff - {24'h00_0000, timeLag_ff};
  logic ptpEdge;
  assign ptpEdge = tick2_ff && !tick3_ff;

  // input: one reassembly ring per flow, each flow in a priority class
  logic [7:0] qMem [FLOWS][QDEPTH];
  logic qLast [FLOWS][QDEPTH];
  logic [AW:0] qWr_ff [FLOWS];
  logic [AW:0] qCommit_ff [FLOWS];
  logic [AW:0] qRd_ff [FLOWS];
  logic [FLOWS-1:0] qFull;
  logic [FLOWS-1:0] qHasPkt;
  logic [FLOWS-1:0] flowHi;
  logic [FW-1:0] flowIdx;
  logic [FW-1:0] wrIdx;
  assign flowIdx = inFlow[FW-1:0];
  // session mode is one control bit; direct sessions use ring 0 alone
  assign wrIdx = modeDirect ? '0 : flowIdx;
  genvar g;
  generate
    for (g = 0; g < FLOWS; g++) begin : gq
      assign qFull[g] = (qWr_ff[g][AW-1:0] == qRd_ff[g][AW-1:0]) &&
                        (qWr_ff[g][AW] != qRd_ff[g][AW]);
      assign qHasPkt[g] = qCommit_ff[g] != qRd_ff[g];
      // direct map: upper flows high; else by code
      assign flowHi[g] = directMap ? (g >= FLOWS / 2) : (flowPhb_ff[8*g +: 6] == PHB_EXPEDITED);
    end
  endgenerate
  assign inReady = enable && !qFull[wrIdx];

  // output framing state
  rpd_state_t state_ff;
  logic [7:0] byteCnt_ff;
  logic isNull_ff;
  logic [FW-1:0] qSel_ff;
  logic [7:0] hdr_ff [4];
  logic [7:0] outData_ff;
  logic outFirst_ff;
  logic [5:0] syncIdx_ff;
  logic syncDue_ff;
  logic frameOpen_ff;
  logic inSyncFix_ff;
  logic [7:0] prev_ff;
  logic [2:0] ccNull_ff;
  logic outFire;
  assign outFire = outValid && outReady;
  logic [FLOWS-1:0] rdTake;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int q = 0; q < FLOWS; q++) begin
        qWr_ff[q] <= '0;
        qCommit_ff[q] <= '0;
      end
    end else if (inValid && inReady) begin
      // in-order pass through; stream tag ignored
      // per-flow reassembly, commit on last fragment
      qMem[wrIdx][qWr_ff[wrIdx][AW-1:0]] <= inData;
      qLast[wrIdx][qWr_ff[wrIdx][AW-1:0]] <= inLast;
      qWr_ff[wrIdx] <= qWr_ff[wrIdx] + 1'b1;
      if (modeDirect || inLast) qCommit_ff[wrIdx] <= qWr_ff[wrIdx] + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int q = 0; q < FLOWS; q++) qRd_ff[q] <= '0;
    end else begin
      for (int q = 0; q < FLOWS; q++) begin
        if (rdTake[q]) qRd_ff[q] <= qRd_ff[q] + 1'b1;
      end
    end
  end

  // sync interval timer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ivlCnt_ff <= 32'h0000_0000;
      syncDue_ff <= 1'b0;
    end else begin
      if (state_ff == ST_SYNC && byteCnt_ff == 8'd5) begin
        ivlCnt_ff <= 32'h0000_0000;
        syncDue_ff <= 1'b0;
      end else if (ivlCnt_ff >= syncIvl_ff || ptpEdge) begin
        syncDue_ff <= !modeDirect;
      end else begin
        ivlCnt_ff <= ivlCnt_ff + 32'h0000_0001;
      end
    end
  end

  // sync message bytes, from the frame control field onward
  function automatic logic [7:0] syncByte(input logic [5:0] i, input logic [31:0] ts);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      6'd0: b = SYNC_FC;
      6'd1: b = 8'h00;
      6'd2: b = SYNC_MSG_LEN[15:8];
      6'd3: b = SYNC_MSG_LEN[7:0];
      6'd4, 6'd5: b = 8'h00;
      6'd6, 6'd7, 6'd8, 6'd9, 6'd10, 6'd11: b = SYNC_DEST_MAC[8*(11-i) +: 8];
      6'd12, 6'd13, 6'd14, 6'd15, 6'd16, 6'd17: b = HEADEND_MAC[8*(17-i) +: 8];
      6'd18: b = SYNC_LEN[15:8];
      6'd19: b = SYNC_LEN[7:0];
      6'd20: b = SAP_NULL;
      6'd21: b = SAP_NULL;
      6'd22: b = LLC_UI;
      6'd23: b = SYNC_VERSION;
      6'd24: b = SYNC_TYPE;
      6'd25: b = 8'h00;
      6'd26, 6'd27, 6'd28, 6'd29: b = ts[8*(29-i) +: 8];
      default: b = TS_STUFF;
    endcase
    return b;
  endfunction

  logic [FW-1:0] selIdx;
  logic [7:0] headByte;
  logic headLast;
  assign selIdx = modeDirect ? '0 : qSel_ff;
  assign headByte = qMem[selIdx][qRd_ff[selIdx][AW-1:0]];
  assign headLast = qLast[selIdx][qRd_ff[selIdx][AW-1:0]];
  logic [FW-1:0] pickQ;
  // high class first, higher flow first within a class
  always_comb begin
    pickQ = '0;
    for (int f = 0; f < FLOWS; f++) begin
      if (qHasPkt[f] && !flowHi[f]) pickQ = FW'(f);
    end
    for (int f = 0; f < FLOWS; f++) begin
      if (qHasPkt[f] && flowHi[f]) pickQ = FW'(f);
    end
  end

  // output: 188-byte packets, header then body
  logic [7:0] nxt_outData;
  always_comb begin
    rdTake = '0;
    nxt_outData = outData_ff;
    unique case (state_ff)
      ST_IDLE: nxt_outData = TS_SYNC_BYTE;
      ST_HDR: nxt_outData = hdr_ff[byteCnt_ff[1:0]];
      ST_SYNC: nxt_outData = (byteCnt_ff == 8'd4) ? 8'h00 :
                             syncByte(syncIdx_ff, stampTime);
      ST_BODY: begin
        if (isNull_ff) begin
          nxt_outData = NULL_PAYLOAD;
        end else if (modeDirect) begin
          // pass through; stamp found sync in place
          nxt_outData = inSyncFix_ff ? stampTime[8*(29-syncIdx_ff) +: 8] : headByte;
          rdTake[0] = 1'b1;
        end else if (frameOpen_ff && qHasPkt[qSel_ff]) begin
          nxt_outData = headByte;
          rdTake[qSel_ff] = 1'b1;
        end else begin
          nxt_outData = TS_STUFF;
        end
      end
      default: nxt_outData = TS_STUFF;
    endcase
    // last byte of a packet fetches nothing
    if (!outFire || byteCnt_ff == 8'(TS_BYTES)) rdTake = '0;
  end

  assign outValid = state_ff != ST_IDLE;
  assign outData = outData_ff;
  assign outFirst = outFirst_ff;

  logic pickNull;
  assign pickNull = modeDirect ? !qHasPkt[0] : !((|qHasPkt) || syncDue_ff);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      byteCnt_ff <= 8'h00;
      isNull_ff <= 1'b0;
      qSel_ff <= '0;
      outData_ff <= 8'h00;
      outFirst_ff <= 1'b0;
      syncIdx_ff <= 6'd0;
      frameOpen_ff <= 1'b0;
      inSyncFix_ff <= 1'b0;
      prev_ff <= 8'h00;
      ccNull_ff <= 3'd0;
      nullCnt_ff <= 32'h0000_0000;
      syncCnt_ff <= 32'h0000_0000;
      for (int k = 0; k < 4; k++) hdr_ff[k] <= 8'h00;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (enable) begin
            // null chosen before any timestamp is taken
            isNull_ff <= pickNull;
            if (pickNull) nullCnt_ff <= nullCnt_ff + 32'h0000_0001;
            hdr_ff[0] <= TS_SYNC_BYTE;
            hdr_ff[1] <= pickNull ? TS_NULL_PID_HI : 8'h5F;
            hdr_ff[2] <= pickNull ? TS_NULL_PID_LO : 8'hFE;
            hdr_ff[3] <= TS_NULL_CTL;
            qSel_ff <= pickQ;
            frameOpen_ff <= !pickNull;
            outData_ff <= TS_SYNC_BYTE;
            outFirst_ff <= 1'b1;
            byteCnt_ff <= 8'd1;
            state_ff <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (outFire) begin
            outFirst_ff <= 1'b0;
            outData_ff <= nxt_outData;
            byteCnt_ff <= byteCnt_ff + 8'd1;
            if (byteCnt_ff == 8'd3) begin
              state_ff <= (!isNull_ff && !modeDirect && syncDue_ff) ? ST_SYNC : ST_BODY;
              syncIdx_ff <= 6'd0;
              prev_ff <= 8'h00;
            end
          end
        end
        ST_SYNC: begin
          if (outFire) begin
            outData_ff <= nxt_outData;
            byteCnt_ff <= byteCnt_ff + 8'd1;
            if (byteCnt_ff != 8'd4) syncIdx_ff <= syncIdx_ff + 6'd1;
            if (syncIdx_ff == 6'(SYNC_BYTES - 1)) begin
              syncCnt_ff <= syncCnt_ff + 32'h0000_0001;
              state_ff <= ST_BODY;
            end
          end
        end
        ST_BODY: begin
          if (outFire) begin
            outData_ff <= nxt_outData;
            byteCnt_ff <= byteCnt_ff + 8'd1;
            prev_ff <= headByte;
            // start bit plus 0x00C0 at bytes five and six
            if (modeDirect && byteCnt_ff == 8'd5 && hdr_ff[1][6] &&
                {prev_ff, headByte} == SYNC_MARK) begin
              syncIdx_ff <= 6'd1;
            end else if (modeDirect && syncIdx_ff != 6'd0) begin
              syncIdx_ff <= syncIdx_ff + 6'd1;
            end
            inSyncFix_ff <= modeDirect && syncIdx_ff >= 6'(SYNC_TS_FIRST - 1) &&
                            syncIdx_ff < 6'(SYNC_TS_FIRST + 3) && syncIdx_ff != 6'd0;
            if (!modeDirect && rdTake[qSel_ff] && headLast) begin
              frameOpen_ff <= 1'b0;
            end
            if (byteCnt_ff == 8'(TS_BYTES)) begin
              state_ff <= ST_IDLE;
              syncIdx_ff <= 6'd0;
              inSyncFix_ff <= 1'b0;
              ccNull_ff <= ccNull_ff + 3'd1;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule : rpd_downstream_path
`default_nettype wire

// ==== src/rpd_pkg.sv ====
// constants and types for the remote phy node downstream path
package rpd_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_SYNC_IVL = 12'h008;
  localparam logic [11:0] ADDR_TIME_NOW = 12'h00C;
  localparam logic [11:0] ADDR_FLOW_PHB = 12'h010;
  localparam logic [11:0] ADDR_NULL_CNT = 12'h014;
  localparam logic [11:0] ADDR_SYNC_CNT = 12'h018;
  localparam logic [11:0] ADDR_TIME_LAG = 12'h01C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SYNC_IVL_RESET = 32'h0000_0800;
  localparam logic [31:0] FLOW_PHB_RESET = 32'h0000_002E;
  localparam logic [7:0] TIME_LAG_RESET = 8'h00;
  localparam logic [7:0] TIME_LAG_MAX = 8'h64;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_DIRECT_MAP_BIT = 2;
  localparam logic [5:0] PHB_EXPEDITED = 6'h2E;
  localparam logic [5:0] PHB_BEST_EFFORT = 6'h00;
  localparam int TS_BYTES = 188;
  localparam logic [7:0] TS_SYNC_BYTE = 8'h47;
  localparam logic [7:0] TS_NULL_PID_HI = 8'h1F;
  localparam logic [7:0] TS_NULL_PID_LO = 8'hFF;
  localparam logic [7:0] TS_NULL_CTL = 8'h10;
  localparam logic [7:0] TS_STUFF = 8'hFF;
  localparam logic [15:0] SYNC_MARK = 16'h00C0;
  localparam logic [7:0] SYNC_FC = 8'hC0;
  localparam logic [7:0] SAP_NULL = 8'h00;
  localparam logic [7:0] LLC_UI = 8'h03;
  localparam logic [7:0] SYNC_VERSION = 8'h01;
  localparam logic [7:0] SYNC_TYPE = 8'h01;
  localparam logic [15:0] SYNC_LEN = 16'h000C;
  localparam logic [15:0] SYNC_MSG_LEN = 16'h0012;
  localparam int SYNC_TS_FIRST = 26;
  localparam int SYNC_BYTES = 36;
  localparam int MCLK_KHZ = 10000;
  localparam int TSCLK_HZ = 10240000;
  localparam logic [7:0] NULL_PAYLOAD = 8'hFF;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HDR = 4'b0010,
    ST_BODY = 4'b0100,
    ST_SYNC = 4'b1000
  } rpd_state_t;
endpackage : rpd_pkg

// ==== test/rpd_downstream_path_asserts.sv ====
// port checker for the downstream path
`timescale 1ns/1ps
`default_nettype none
module rpd_downstream_path_asserts import rpd_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic inReady,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [7:0] outData,
  input wire logic outFirst
);
  logic [7:0] idxFf;
  logic h1Ff;
  logic nullFf;
  logic b4Ff;
  logic syncFf;
  logic enFf;
  wire logic go = outValid && outReady;
  // byte position in packet
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) idxFf <= 8'h00;
    else if (go) idxFf <= (idxFf == 8'hBB) ? 8'h00 : idxFf + 8'h01;
  end
  // null and sync packet recognition
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      h1Ff <= 1'b0;
      nullFf <= 1'b0;
      b4Ff <= 1'b0;
      syncFf <= 1'b0;
    end else if (go) begin
      if (idxFf == 8'h01) h1Ff <= outData == TS_NULL_PID_HI;
      if (idxFf == 8'h02) nullFf <= h1Ff && outData == TS_NULL_PID_LO;
      if (idxFf == 8'h04) b4Ff <= outData == 8'h00;
      if (idxFf == 8'h05) syncFf <= b4Ff && outData == SYNC_FC;
    end
  end
  // enable bit as last written
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) enFf <= 1'b0;
    else if (psel && penable && pwrite && paddr == ADDR_CTRL) enFf <= pwdata[CTRL_ENABLE_BIT];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_first_sync; outValid && outFirst |-> outData == TS_SYNC_BYTE; endproperty
  a_first_sync: assert property (p_first_sync) else $error("bad start byte");
  property p_first_pos; outValid |-> outFirst == (idxFf == 8'h00); endproperty
  a_first_pos: assert property (p_first_pos) else $error("packet length wrong");
  property p_hold; outValid && !outReady |=> outValid && $stable(outData); endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_null_ctl; outValid && nullFf && idxFf == 8'h03 |-> outData == TS_NULL_CTL; endproperty
  a_null_ctl: assert property (p_null_ctl) else $error("null control byte");
  property p_null_body; outValid && nullFf && idxFf > 8'h03 |-> outData == NULL_PAYLOAD;
  endproperty
  a_null_body: assert property (p_null_body) else $error("null payload byte");
  property p_sync_llc;
    outValid && syncFf && idxFf inside {8'h19, 8'h1A, 8'h1B}
      |-> outData == ((idxFf == 8'h1B) ? LLC_UI : SAP_NULL);
  endproperty
  a_sync_llc: assert property (p_sync_llc) else $error("sync llc header");
  property p_sync_ver;
    outValid && syncFf && idxFf inside {8'h1C, 8'h1D}
      |-> outData == (idxFf[0] ? SYNC_TYPE : SYNC_VERSION);
  endproperty
  a_sync_ver: assert property (p_sync_ver) else $error("sync version or type");
  property p_off_ready; !enFf |-> !inReady; endproperty
  a_off_ready: assert property (p_off_ready) else $error("ready while disabled");
endmodule : rpd_downstream_path_asserts
bind rpd_downstream_path rpd_downstream_path_asserts u_chk (.mclk, .reset_n, .paddr, .psel,
  .penable, .pwrite, .pwdata, .inReady, .outValid, .outReady, .outData, .outFirst);
`default_nettype wire

// ==== test/rpd_headend_src.sv ====
// headend core model feeding pseudowire bytes
`timescale 1ns/1ps
`default_nettype none
module rpd_headend_src (
  input wire logic mclk,
  input wire logic inReady,
  output logic inValid,
  output logic [7:0] inData,
  output logic inFirst,
  output logic inLast,
  output logic [1:0] inFlow,
  output logic [3:0] inStreamTag
);
  initial {inValid, inData, inFirst, inLast, inFlow, inStreamTag} = '0;
  // one fragment group on one flow, line released after
  task automatic send(input logic [1:0] f, input logic [7:0] b[$], input logic st, input logic en);
    @(posedge mclk);
    for (int i = 0; i < b.size(); i++) begin
      inValid <= 1'b1;
      inFlow <= f;
      inData <= b[i];
      inFirst <= st && i == 0;
      inLast <= en && i == b.size() - 1;
      @(posedge mclk);
      while (inReady !== 1'b1) @(posedge mclk);
    end
    inValid <= 1'b0;
    inData <= ~inData;
  endtask : send
endmodule : rpd_headend_src
`default_nettype wire

// ==== test/rpd_downstream_path_tb_top.sv ====
// self-checking bench for the downstream path
`timescale 1ns/1ps
`default_nettype none
module rpd_downstream_path_tb_top import rpd_pkg::*; ();
  localparam logic [47:0] DEST = 48'h0A00_0000_00B7; // arbitrary value
  typedef logic [7:0] rpd_q_t[$];
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, m, x; logic e;} rpd_row_t;
  rpd_row_t rows[12] = '{
    '{1'b0, ADDR_CTRL, '0, '1, CTRL_RESET, 1'b0},
    '{1'b0, ADDR_SYNC_IVL, '0, '1, SYNC_IVL_RESET, 1'b0},
    '{1'b0, ADDR_FLOW_PHB, '0, 32'h0000_00FF, FLOW_PHB_RESET, 1'b0},
    '{1'b0, ADDR_TIME_LAG, '0, 32'h0000_00FF, 32'(TIME_LAG_RESET), 1'b0},
    '{1'b1, ADDR_TIME_LAG, 32'h0000_00FF, '0, '0, 1'b0},
    '{1'b0, ADDR_TIME_LAG, '0, 32'h0000_00FF, 32'(TIME_LAG_MAX), 1'b0},
    '{1'b1, 12'h040, 32'h0000_0001, '0, '0, 1'b1},
    '{1'b0, 12'h040, '0, '1, '0, 1'b1},
    '{1'b1, ADDR_SYNC_IVL, 32'h0000_0258, '0, '0, 1'b0},
    '{1'b0, ADDR_SYNC_IVL, '0, '1, 32'h0000_0258, 1'b0},
    '{1'b1, ADDR_FLOW_PHB, 32'h0000_002E, '0, '0, 1'b0},
    '{1'b1, ADDR_CTRL, 32'h0000_0002, '0, '0, 1'b0}};
  logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = '0, prdata, rd, t0;
  logic pready, pslverr, inValid, inReady, inFirst, inLast, outValid, outFirst, err, tsOn;
  logic outReady = 1'b1, ptpTick = 1'b0;
  logic [7:0] inData, outData, pkt[188], syncPkt[188];
  logic [1:0] inFlow;
  logic [3:0] inStreamTag;
  rpd_q_t seen, dp;
  int failCount = 0, testsRun = 0, cyc = 0, pos = 0, nulls = 0, syncs = 0, maxGap = 0;
  int lastCyc, pc, aCyc, c0, n0, d;
  logic [31:0] lastTs;
  longint dd;
  rpd_downstream_path #(.SYNC_DEST_MAC(DEST)) u_dut (.mclk, .reset_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .inValid, .inReady, .inData, .inFirst,
    .inLast, .inFlow, .inStreamTag, .outValid, .outReady, .outData, .outFirst, .ptpTick);
  rpd_headend_src u_src (.mclk, .inReady, .inValid, .inData, .inFirst, .inLast, .inFlow,
    .inStreamTag);
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic chk(input logic ok, input string m);
    testsRun++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic printVerdict();
    $display("checks %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : printVerdict
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    aCyc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic rpd_q_t fill(input logic [7:0] v, input int n);
    rpd_q_t q;
    repeat (n) q.push_back(v);
    return q;
  endfunction : fill
  function automatic int find(input logic [7:0] v);
    foreach (seen[i]) if (seen[i] === v) return i;
    return -1000;
  endfunction : find
  // sorts finished packets into null and sync
  task automatic chkPkt();
    logic [31:0] ts;
    if (pkt[1] === TS_NULL_PID_HI && pkt[2] === TS_NULL_PID_LO) nulls++;
    if (pkt[4] === 8'h00 && pkt[5] === SYNC_FC) begin
      syncPkt = pkt;
      ts = {pkt[31], pkt[32], pkt[33], pkt[34]};
      if (lastCyc >= 0 && tsOn) begin
        dd = longint'(ts - lastTs) * 1000 - longint'(pc - lastCyc) * 1024;
        chk(dd <= 2048 && dd >= -2048, "sync timestamp step");
        if (pc - lastCyc > maxGap) maxGap = pc - lastCyc;
      end
      lastTs = ts;
      lastCyc = pc;
      syncs++;
    end
  endtask : chkPkt
  always @(negedge mclk) begin
    if (outValid === 1'b1 && outReady === 1'b1) begin
      if (pos == 0) pc = cyc;
      pkt[pos] = outData;
      seen.push_back(outData);
      pos = (pos == 187) ? 0 : pos + 1;
      if (pos == 0) chkPkt();
    end
  end
  initial begin
    #3_000_000;
    failCount++;
    $display("mismatch at %0t: timeout", $time);
    printVerdict();
  end
  initial begin
    tsOn = 1'b0;
    repeat (3) @(posedge mclk);
    chk(outValid === 1'b0 && inReady === 1'b0, "reset outputs");
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk((rd & rows[i].m) === rows[i].x && err === rows[i].e, "register row");
    end
    repeat (400) @(posedge mclk);
    chk(nulls > 1, "no null packets when idle");
    seen.delete();
    for (int f = 0; f < 4; f++) u_src.send(2'(f), fill(8'hA0 + 8'(f), 8), 1'b1, 1'b0);
    for (int f = 0; f < 4; f++) u_src.send(2'(f), fill(8'hB0 + 8'(f), 8), 1'b0, 1'b1);
    repeat (800) @(posedge mclk);
    for (int f = 0; f < 4; f++) begin
      d = find(8'hB0 + 8'(f)) - find(8'hA0 + 8'(f)) - 7;
      chk(find(8'hA0 + 8'(f)) >= 0 && d >= 1 && d <= 6, "flow reassembly");
    end
    for (int k = 0; k < 2; k++) begin
      if (k == 1) apb(1'b1, ADDR_CTRL, 32'h0000_0006);
      outReady <= 1'b0;
      u_src.send(2'h0, fill(8'h92 - 8'(2 * k), 4), 1'b1, 1'b1);
      u_src.send(2'(k * 3 + 1 - k), fill(8'h93 - 8'(2 * k), 4), 1'b1, 1'b1);
      seen.delete();
      outReady <= 1'b1;
      repeat (600) @(posedge mclk);
      n0 = find((k == 1) ? 8'h91 : 8'h92);
      c0 = find((k == 1) ? 8'h90 : 8'h93);
      chk(n0 >= 0 && c0 > n0, "queue order");
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    lastCyc = -1;
    n0 = syncs;
    tsOn = 1'b1;
    repeat (3000) @(posedge mclk);
    tsOn = 1'b0;
    chk(syncs - n0 >= 3 && maxGap <= 1000, "sync spacing");
    for (int k = 0; k < 6; k++) chk(syncPkt[11 + k] === DEST[47 - 8 * k -: 8], "sync dest");
    apb(1'b1, ADDR_SYNC_IVL, 32'h0000_FFFF);
    repeat (300) @(posedge mclk);
    n0 = syncs;
    ptpTick <= 1'b1;
    repeat (4) @(posedge mclk);
    ptpTick <= 1'b0;
    repeat (500) @(posedge mclk);
    chk(syncs > n0, "tick gives sync");
    apb(1'b0, ADDR_TIME_NOW, '0);
    t0 = rd;
    c0 = aCyc;
    repeat (1000) @(posedge mclk);
    apb(1'b0, ADDR_TIME_NOW, '0);
    dd = longint'(rd - t0) * 1000 - longint'(aCyc - c0) * 1024;
    chk(dd <= 2048 && dd >= -2048, "time count rate");
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    dp = fill(8'h00, 184);
    foreach (dp[i]) dp[i] = 8'(i) ^ 8'h5A;
    {dp[0], dp[1], dp[21], dp[22], dp[23]} = {8'h00, SYNC_FC, SAP_NULL, SAP_NULL, LLC_UI};
    {dp[24], dp[25], dp[27], dp[28], dp[29], dp[30]} = {SYNC_VERSION, SYNC_TYPE, 32'h0};
    n0 = syncs;
    u_src.send(2'h0, dp, 1'b1, 1'b1);
    repeat (800) @(posedge mclk);
    chk(syncs == n0 + 1 && syncPkt[1] === 8'h5F, "direct sync packet");
    for (int k = 4; k < 188; k++) begin
      if (k < 31 || k > 34) chk(syncPkt[k] === dp[k - 4], "direct payload");
    end
    printVerdict();
  end
endmodule : rpd_downstream_path_tb_top
`default_nettype wire
